// >>> design/cmsl_pkg.sv
// Constants, state codes and timing counts of the configuration mode select loader.
// Assumes a 250 MHz core clock standing for the internal oscillator.
// Operation
// - Sample select after reset or long reset-pin pulse
// - Select pin reads high when undriven
// - Select high, store programmed: load from store
// - Select high, store blank: read external flash
// - Select low: wait for host serial load
// - Internal oscillator clocks all non-peripheral modes
// - Hold reset until all supplies are good
// - RAM write protected during configuration
// - RAM preload from bitstream is optional
// - RAM read data register not reset
// - Security bits block store readout
// - Store programmable over serial-flash-like port; here a parallel write port, user mode only
// - Peripheral mode clocked by host serial clock
// - Release done pull-down at end of load
// - User I/O active after 49 clocks
package cmsl_pkg;
   localparam int unsigned CLK_PERIOD_PS   = 4000;
   localparam int unsigned RST_LOW_MIN_NS  = 250;
   localparam int unsigned RST_LOW_MIN_CYC =
      (RST_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [6:0]  RST_LOW_MIN     = 7'(RST_LOW_MIN_CYC);
   localparam int unsigned WAKE_CYCLES     = 49;
   localparam logic [5:0]  WAKE_LAST       = 6'(WAKE_CYCLES - 1);
   localparam logic [7:0]  FAST_READ_CMD   = 8'h0B;
   localparam logic [23:0] FLASH_START     = 24'h000000;
   localparam logic [7:0]  DUMMY_BYTE      = 8'h00;
   localparam logic [5:0]  HDR_BITS        = 6'h28;
   localparam logic [2:0]  BYTE_LAST_BIT   = 3'h7;
   localparam int unsigned SCK_HALF_DEF    = 4;
   localparam int unsigned FIFO_DEPTH_DEF  = 8;
   localparam int unsigned LOGIC_BYTES_DEF = 64;
   localparam int unsigned RAM_BYTES_DEF   = 32;

   typedef enum logic [2:0] {
      CMSL_RESET  = 3'b000,
      CMSL_SAMPLE = 3'b001,
      CMSL_STORE  = 3'b010,
      CMSL_FLASH  = 3'b011,
      CMSL_PERIPH = 3'b100,
      CMSL_WAKE   = 3'b101,
      CMSL_USER   = 3'b110
   } cmsl_state_t;
endpackage

// >>> design/cmsl_top.sv
// Configuration mode select loader: source choice, byte loaders, FIFO and wake-up.
// Assumes pins arrive asynchronously and the host serial clock may stop between frames.
`timescale 1ns/1ps

module cmsl_fifo #(
   parameter int unsigned W     = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("FIFO depth must be a power of two of at least two.");
      end
   endgenerate
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = cnt_q != FULL_CNT;
   assign out_valid = cnt_q != '0;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_q + AW'(push);
         rd_q  <= rd_q + AW'(pop);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module cmsl_top import cmsl_pkg::*; #(
   parameter int unsigned LOGIC_BYTES = LOGIC_BYTES_DEF,
   parameter int unsigned RAM_BYTES   = RAM_BYTES_DEF,
   parameter int unsigned SCK_HALF    = SCK_HALF_DEF,
   parameter int unsigned FIFO_DEPTH  = FIFO_DEPTH_DEF,
   parameter int unsigned STORE_AW    = 16,
   parameter int unsigned RAM_W       = 16
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                supplies_ok,
   input  wire logic                config_reset_n,
   input  wire logic                spi_ss_n_i,
   output logic                     spi_ss_n_o,
   output logic                     spi_ss_n_oe,
   output logic                     spi_ss_n_pullup,
   input  wire logic                spi_sck_i,
   output logic                     spi_sck_o,
   output logic                     spi_sck_oe,
   output logic                     spi_mosi_o,
   output logic                     spi_mosi_oe,
   input  wire logic                spi_miso_i,
   input  wire logic                per_sdi_i,
   input  wire logic                store_programmed,
   input  wire logic                security_set,
   input  wire logic                ram_preload_en,
   output logic                     store_rd_en,
   output logic [STORE_AW-1:0]      store_rd_addr,
   input  wire logic [7:0]          store_rd_data,
   input  wire logic                ext_rd_en,
   input  wire logic [STORE_AW-1:0] ext_rd_addr,
   output logic                     ext_rd_valid,
   output logic [7:0]               ext_rd_data,
   input  wire logic                prog_wr_en,
   input  wire logic [STORE_AW-1:0] prog_wr_addr,
   input  wire logic [7:0]          prog_wr_data,
   output logic                     store_wr_en,
   output logic [STORE_AW-1:0]      store_wr_addr,
   output logic [7:0]               store_wr_data,
   output logic                     cfg_valid,
   input  wire logic                cfg_ready,
   output logic [7:0]               cfg_data,
   output logic                     cfg_overflow,
   output logic                     config_finished_o,
   output logic                     config_finished_oe,
   output logic                     user_io_en,
   output logic                     ram_write_protect,
   input  wire logic                ram_we_i,
   output logic                     ram_we_o,
   input  wire logic                ram_re,
   input  wire logic [RAM_W-1:0]    ram_array_q,
   output logic [RAM_W-1:0]         ram_rd_data
);
   generate
      if (SCK_HALF < 3 || SCK_HALF > 15 || LOGIC_BYTES < 1
          || LOGIC_BYTES + RAM_BYTES >= (1 << STORE_AW)) begin : g_bad_param
         $error("Loader parameters out of range.");
      end
   endgenerate
   localparam logic [STORE_AW-1:0] LEN_LOGIC = STORE_AW'(LOGIC_BYTES);
   localparam logic [STORE_AW-1:0] LEN_FULL  = STORE_AW'(LOGIC_BYTES + RAM_BYTES);
   localparam logic [3:0]          HALF_LAST = 4'(SCK_HALF - 1);

   cmsl_state_t         state_q;
   logic [4:0]          sync1_q;
   logic [4:0]          sync2_q;
   logic                tog_seen_q;
   logic                creset_prev_q;
   logic [6:0]          low_cnt_q;
   logic                restart;
   logic                sel_q;
   logic [STORE_AW-1:0] len_q;
   logic [STORE_AW-1:0] src_cnt_q;
   logic [STORE_AW-1:0] out_cnt_q;
   logic [5:0]          wake_q;
   logic [7:0]          hold_q;
   logic                hold_v_q;
   logic                hold_ready;
   logic                rd_pend_q;
   logic                load_rd;
   logic                src_more;
   logic                per_byte_ev;
   logic                flash_act;
   logic [3:0]          div_q;
   logic                sck_q;
   logic [39:0]         cmd_q;
   logic [5:0]          hdr_q;
   logic [7:0]          rx_q;
   logic [2:0]          rxb_q;
   logic                half_ev;
   logic                drain;
   logic [2:0]          per_bits_q;
   logic [6:0]          per_sr_q;
   logic [7:0]          per_byte_q;
   logic                per_tog_q;
   logic                sck_rst;
   logic                fifo_in_ready;
   logic                ext_pend_q;

   // Index 0 supply monitor, 1 reset pin, 2 select pin, 3 flash data, 4 peripheral toggle.
   wire supplies_s = sync2_q[0];
   wire creset_s   = sync2_q[1];
   wire ss_s       = sync2_q[2];
   wire miso_s     = sync2_q[3];
   wire tog_s      = sync2_q[4];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 5'h06;
         sync2_q <= 5'h06;
      end else begin
         sync1_q <= {per_tog_q, spi_miso_i, spi_ss_n_i, config_reset_n, supplies_ok};
         sync2_q <= sync1_q;
      end
   end

   // A short glitch on the reset pin is ignored; only a long low pulse restarts.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_q     <= '0;
         creset_prev_q <= 1'b1;
      end else begin
         creset_prev_q <= creset_s;
         if (creset_s) begin
            low_cnt_q <= '0;
         end else if (low_cnt_q != 7'h7F) begin
            low_cnt_q <= low_cnt_q + 7'h01;
         end
      end
   end
   assign restart = (creset_s & ~creset_prev_q & (low_cnt_q >= RST_LOW_MIN))
                    | ~supplies_s;

   assign src_more  = src_cnt_q != len_q;
   assign hold_ready = hold_v_q & fifo_in_ready;
   assign drain     = cfg_valid & cfg_ready;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= CMSL_RESET;
         sel_q   <= 1'b1;
         len_q   <= LEN_LOGIC;
         wake_q  <= '0;
      end else if (restart) begin
         state_q <= CMSL_RESET;
      end else begin
         case (state_q)
            CMSL_RESET: begin
               if (creset_s) begin
                  state_q <= CMSL_SAMPLE;
               end
            end
            CMSL_SAMPLE: begin
               sel_q   <= ss_s;
               len_q   <= ram_preload_en ? LEN_FULL : LEN_LOGIC;
               if (!ss_s) begin
                  state_q <= CMSL_PERIPH;
               end else if (store_programmed) begin
                  state_q <= CMSL_STORE;
               end else begin
                  state_q <= CMSL_FLASH;
               end
            end
            CMSL_STORE, CMSL_FLASH, CMSL_PERIPH: begin
               wake_q <= '0;
               if (drain && out_cnt_q == len_q - STORE_AW'(1)) begin
                  state_q <= CMSL_WAKE;
               end
            end
            CMSL_WAKE: begin
               wake_q <= wake_q + 6'h01;
               if (wake_q == WAKE_LAST) begin
                  state_q <= CMSL_USER;
               end
            end
            CMSL_USER: state_q <= CMSL_USER;
            default: state_q <= CMSL_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_cnt_q <= '0;
      end else if (state_q == CMSL_SAMPLE) begin
         out_cnt_q <= '0;
      end else if (drain) begin
         out_cnt_q <= out_cnt_q + STORE_AW'(1);
      end
   end

   // Store loader issues one read at a time, so the hold register never overflows.
   assign load_rd = (state_q == CMSL_STORE) & src_more & ~hold_v_q & ~rd_pend_q;
   assign store_rd_en   = load_rd | (ext_rd_en & (state_q == CMSL_USER));
   assign store_rd_addr = load_rd ? src_cnt_q : ext_rd_addr;

   // The flash clock pauses while a byte waits, so the flash is throttled by the FIFO.
   assign flash_act = (state_q == CMSL_FLASH) & src_more;
   assign half_ev   = flash_act & ~hold_v_q & (div_q == HALF_LAST);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
         sck_q <= 1'b0;
         cmd_q <= '0;
         hdr_q <= '0;
         rx_q  <= '0;
         rxb_q <= '0;
      end else if (state_q == CMSL_SAMPLE) begin
         div_q <= '0;
         sck_q <= 1'b0;
         cmd_q <= {FAST_READ_CMD, FLASH_START, DUMMY_BYTE};
         hdr_q <= '0;
         rxb_q <= '0;
      end else if (flash_act && !hold_v_q) begin
         div_q <= half_ev ? 4'h0 : div_q + 4'h1;
         if (half_ev) begin
            sck_q <= ~sck_q;
            if (sck_q) begin
               cmd_q <= {cmd_q[38:0], 1'b0};
            end else if (hdr_q != HDR_BITS) begin
               hdr_q <= hdr_q + 6'h01;
            end else begin
               rx_q  <= {rx_q[6:0], miso_s};
               rxb_q <= rxb_q + 3'h1;
            end
         end
      end
   end
   wire flash_byte = half_ev & ~sck_q & (hdr_q == HDR_BITS) & (rxb_q == BYTE_LAST_BIT);

   assign per_byte_ev = (tog_s != tog_seen_q) & (state_q == CMSL_PERIPH) & src_more;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q       <= '0;
         hold_v_q     <= 1'b0;
         rd_pend_q    <= 1'b0;
         src_cnt_q    <= '0;
         tog_seen_q   <= 1'b0;
         cfg_overflow <= 1'b0;
      end else begin
         tog_seen_q <= tog_s;
         rd_pend_q  <= load_rd;
         if (state_q == CMSL_SAMPLE) begin
            hold_v_q     <= 1'b0;
            src_cnt_q    <= '0;
            cfg_overflow <= 1'b0;
         end else if (rd_pend_q) begin
            hold_q    <= store_rd_data;
            hold_v_q  <= 1'b1;
            src_cnt_q <= src_cnt_q + STORE_AW'(1);
         end else if (flash_byte) begin
            hold_q    <= {rx_q[6:0], miso_s};
            hold_v_q  <= 1'b1;
            src_cnt_q <= src_cnt_q + STORE_AW'(1);
         end else if (per_byte_ev) begin
            // The host cannot be stalled; a byte arriving on a full path is lost.
            if (hold_v_q && !fifo_in_ready) begin
               cfg_overflow <= 1'b1;
            end else begin
               hold_q    <= per_byte_q;
               hold_v_q  <= 1'b1;
               src_cnt_q <= src_cnt_q + STORE_AW'(1);
            end
         end else if (hold_ready) begin
            hold_v_q <= 1'b0;
         end
      end
   end

   cmsl_fifo #(
      .W     (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .flush     (state_q == CMSL_SAMPLE),
      .in_valid  (hold_v_q),
      .in_ready  (fifo_in_ready),
      .in_data   (hold_q),
      .out_valid (cfg_valid),
      .out_ready (cfg_ready),
      .out_data  (cfg_data)
   );

   // Peripheral link: bit state ends with the frame, byte and toggle outlive it.
   assign sck_rst = rst | spi_ss_n_i;
   always_ff @(posedge spi_sck_i or posedge sck_rst) begin
      if (sck_rst) begin
         per_bits_q <= '0;
         per_sr_q   <= '0;
      end else begin
         per_bits_q <= per_bits_q + 3'h1;
         per_sr_q   <= {per_sr_q[5:0], per_sdi_i};
      end
   end
   always_ff @(posedge spi_sck_i or posedge rst) begin
      if (rst) begin
         per_byte_q <= '0;
         per_tog_q  <= 1'b0;
      end else if (!spi_ss_n_i && per_bits_q == BYTE_LAST_BIT) begin
         per_byte_q <= {per_sr_q, per_sdi_i};
         per_tog_q  <= ~per_tog_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_pend_q    <= 1'b0;
         ext_rd_valid  <= 1'b0;
         ext_rd_data   <= '0;
         store_wr_en   <= 1'b0;
         store_wr_addr <= '0;
         store_wr_data <= '0;
      end else begin
         ext_pend_q    <= ext_rd_en & (state_q == CMSL_USER);
         ext_rd_valid  <= ext_pend_q;
         ext_rd_data   <= security_set ? 8'h00 : store_rd_data;
         store_wr_en   <= prog_wr_en & (state_q == CMSL_USER);
         store_wr_addr <= prog_wr_addr;
         store_wr_data <= prog_wr_data;
      end
   end

   // The read register keeps whatever it held across configuration.
   always_ff @(posedge clk) begin
      if (ram_re) begin
         ram_rd_data <= ram_array_q;
      end
   end

   assign spi_ss_n_pullup    = 1'b1;
   assign spi_ss_n_o         = ~flash_act;
   assign spi_ss_n_oe        = state_q == CMSL_FLASH;
   assign spi_sck_o          = sck_q;
   assign spi_sck_oe         = state_q == CMSL_FLASH;
   assign spi_mosi_o         = cmd_q[39];
   assign spi_mosi_oe        = state_q == CMSL_FLASH;
   assign config_finished_o  = 1'b0;
   assign config_finished_oe = (state_q != CMSL_WAKE) && (state_q != CMSL_USER);
   assign user_io_en         = state_q == CMSL_USER;
   assign ram_write_protect  = state_q != CMSL_USER;
   assign ram_we_o           = ram_we_i & (state_q == CMSL_USER);
endmodule

// >>> tb/cmsl_top_sva.sv
// Concurrent checks on the loader's ports: wake timing, RAM guard and store port.
// Assumes it is bound into cmsl_top and that all checked logic runs on clk.
`timescale 1ns/1ps
module cmsl_sva #(
   parameter int unsigned STORE_AW = 16,
   parameter int unsigned RAM_W    = 16
) (
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                spi_ss_n_oe,
   input wire logic                spi_sck_oe,
   input wire logic                spi_mosi_oe,
   input wire logic                security_set,
   input wire logic                ext_rd_en,
   input wire logic                ext_rd_valid,
   input wire logic [7:0]          ext_rd_data,
   input wire logic                prog_wr_en,
   input wire logic [STORE_AW-1:0] prog_wr_addr,
   input wire logic [7:0]          prog_wr_data,
   input wire logic                store_wr_en,
   input wire logic [STORE_AW-1:0] store_wr_addr,
   input wire logic [7:0]          store_wr_data,
   input wire logic                cfg_valid,
   input wire logic                cfg_ready,
   input wire logic [7:0]          cfg_data,
   input wire logic                config_finished_oe,
   input wire logic                user_io_en,
   input wire logic                ram_we_i,
   input wire logic                ram_we_o,
   input wire logic                ram_re,
   input wire logic [RAM_W-1:0]    ram_array_q,
   input wire logic [RAM_W-1:0]    ram_rd_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles with the done pull-down off and user I/O held back.
   logic [6:0] wake_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_q <= 7'h00;
      end else if (config_finished_oe || user_io_en) begin
         wake_q <= 7'h00;
      end else begin
         wake_q <= wake_q + 7'h01;
      end
   end
   sequence s_ext_ask;
      ext_rd_en && user_io_en;
   endsequence
   sequence s_prog_ask;
      prog_wr_en && user_io_en;
   endsequence
   sequence s_prog_done;
      store_wr_en && store_wr_addr == $past(prog_wr_addr) && store_wr_data == $past(prog_wr_data);
   endsequence
   chk_ram_we_gate: assert property (ram_we_o == (ram_we_i && user_io_en))
      else $error("RAM write passed while protected");
   chk_done_released: assert property (user_io_en |-> !config_finished_oe)
      else $error("done pull-down still on in user mode");
   chk_wake_length: assert property ($rose(user_io_en) |-> wake_q inside {7'h30, 7'h31})
      else $error("user I/O wake delay wrong");
   chk_secure_read: assert property (
      ext_rd_valid && security_set && $past(security_set) |-> ext_rd_data == 8'h00)
      else $error("secured store readable");
   chk_ext_answer: assert property (s_ext_ask |-> ##2 ext_rd_valid)
      else $error("store read not answered");
   chk_prog_write: assert property (s_prog_ask |=> s_prog_done)
      else $error("store write not passed on");
   chk_prog_refused: assert property (prog_wr_en && !user_io_en |=> !store_wr_en)
      else $error("store written during load");
   chk_rd_capture: assert property (
      ram_re && user_io_en |=> ram_rd_data == $past(ram_array_q))
      else $error("RAM read data not captured");
   chk_stream_hold: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
      else $error("stream byte lost while stalled");
   chk_master_quiet: assert property (
      user_io_en |-> !(spi_ss_n_oe || spi_sck_oe || spi_mosi_oe))
      else $error("flash pins driven in user mode");
endmodule
bind cmsl_top cmsl_sva #(.STORE_AW(STORE_AW), .RAM_W(RAM_W)) i_sva (
   .clk(clk), .rst(rst), .spi_ss_n_oe(spi_ss_n_oe), .spi_sck_oe(spi_sck_oe),
   .spi_mosi_oe(spi_mosi_oe), .security_set(security_set), .ext_rd_en(ext_rd_en),
   .ext_rd_valid(ext_rd_valid), .ext_rd_data(ext_rd_data), .prog_wr_en(prog_wr_en),
   .prog_wr_addr(prog_wr_addr), .prog_wr_data(prog_wr_data), .store_wr_en(store_wr_en),
   .store_wr_addr(store_wr_addr), .store_wr_data(store_wr_data), .cfg_valid(cfg_valid),
   .cfg_ready(cfg_ready), .cfg_data(cfg_data), .config_finished_oe(config_finished_oe),
   .user_io_en(user_io_en), .ram_we_i(ram_we_i), .ram_we_o(ram_we_o), .ram_re(ram_re),
   .ram_array_q(ram_array_q), .ram_rd_data(ram_rd_data));

// >>> tb/cmsl_partner.sv
// Far-side models: a serial flash answering fast read, and the on-chip store array.
// Assumes the bench resolves the chip-select and clock pins before they arrive here.
`timescale 1ns/1ps
module cmsl_partner #(
   parameter int unsigned STORE_AW = 16,
   parameter realtime     LAG      = 1.0
) (
   input  wire logic                clk,
   input  wire logic                ss_n,
   input  wire logic                sck,
   output logic                     miso,
   input  wire logic                rd_en,
   input  wire logic [STORE_AW-1:0] rd_addr,
   output logic [7:0]               rd_data
);
   int         bit_n;
   logic [7:0] cur;
   initial begin
      bit_n   = 0;
      miso    = 1'b0;
      rd_data = 8'h00;
   end
   always @(negedge ss_n) begin
      bit_n = 0;
   end
   always @(posedge sck) begin
      if (!ss_n) begin
         bit_n = bit_n + 1;
      end
   end
   // Command, address and dummy bits take 40 clocks; data then follows MSB first.
   always @(negedge sck) begin
      if (!ss_n && bit_n >= 40) begin
         cur = 8'hA5 + 8'((bit_n - 40) / 8) * 8'h11;
         miso <= #LAG cur[7 - (bit_n - 40) % 8];
      end
   end
   // A deselected flash floats its output, so the last level must not linger.
   always @(posedge ss_n) begin
      miso <= ~miso;
   end
   always @(posedge clk) begin
      if (rd_en) begin
         rd_data <= 8'h3C ^ rd_addr[7:0];
      end
   end
endmodule

// >>> tb/cmsl_top_bench.sv
// Bench for cmsl_top: store, flash and host loads, restarts and user-mode ports.
// Assumes cmsl_partner stands for flash and store; the host link is driven here.
`timescale 1ns/1ps
module cmsl_top_bench;
   localparam int LB = 4;
   localparam int RB = 2;
   logic        clk, rst, supplies_ok, config_reset_n, spi_sck_i, per_sdi_i, spi_miso_i;
   logic        store_programmed, security_set, ram_preload_en, ext_rd_en, prog_wr_en;
   logic        cfg_ready, ram_we_i, ram_re, store_rd_en, store_wr_en, cfg_valid;
   logic        user_io_en, ram_we_o, spi_ss_n_o, spi_ss_n_oe, spi_sck_o, spi_sck_oe;
   logic        host_en, host_ss, rand_en, ss_pin, flash_ss, flash_sck;
   logic [15:0] store_rd_addr, ext_rd_addr, prog_wr_addr, ram_array_q, ram_rd_data, v;
   logic [7:0]  store_rd_data, ext_rd_data, prog_wr_data, store_wr_data, cfg_data;
   logic [7:0]  exp_q[$];
   int          err_count, tests_run;
   assign ss_pin    = spi_ss_n_oe ? spi_ss_n_o : (host_en ? host_ss : 1'b1);
   assign flash_ss  = !(spi_ss_n_oe && !spi_ss_n_o);
   assign flash_sck = spi_sck_oe && spi_sck_o;
   always #2 clk = ~clk;
   cmsl_top #(.LOGIC_BYTES(LB), .RAM_BYTES(RB)) i_dut (
      .clk(clk), .rst(rst), .supplies_ok(supplies_ok), .config_reset_n(config_reset_n),
      .spi_ss_n_i(ss_pin), .spi_ss_n_o(spi_ss_n_o), .spi_ss_n_oe(spi_ss_n_oe),
      .spi_ss_n_pullup(), .spi_sck_i(spi_sck_i), .spi_sck_o(spi_sck_o),
      .spi_sck_oe(spi_sck_oe), .spi_mosi_o(), .spi_mosi_oe(), .spi_miso_i(spi_miso_i),
      .per_sdi_i(per_sdi_i), .store_programmed(store_programmed),
      .security_set(security_set), .ram_preload_en(ram_preload_en),
      .store_rd_en(store_rd_en), .store_rd_addr(store_rd_addr),
      .store_rd_data(store_rd_data), .ext_rd_en(ext_rd_en), .ext_rd_addr(ext_rd_addr),
      .ext_rd_valid(), .ext_rd_data(ext_rd_data), .prog_wr_en(prog_wr_en),
      .prog_wr_addr(prog_wr_addr), .prog_wr_data(prog_wr_data), .store_wr_en(store_wr_en),
      .store_wr_addr(), .store_wr_data(store_wr_data), .cfg_valid(cfg_valid),
      .cfg_ready(cfg_ready), .cfg_data(cfg_data), .cfg_overflow(), .config_finished_o(),
      .config_finished_oe(), .user_io_en(user_io_en), .ram_write_protect(),
      .ram_we_i(ram_we_i), .ram_we_o(ram_we_o), .ram_re(ram_re),
      .ram_array_q(ram_array_q), .ram_rd_data(ram_rd_data));
   cmsl_partner i_far (.clk(clk), .ss_n(flash_ss), .sck(flash_sck), .miso(spi_miso_i),
      .rd_en(store_rd_en), .rd_addr(store_rd_addr), .rd_data(store_rd_data));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("errors=%0d checks=%0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task push_exp(input logic fl, input int n);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(fl ? 8'hA5 + 8'(i) * 8'h11 : 8'h3C ^ 8'(i));
      end
   endtask
   task wait_user;
      int n;
      n = 0;
      while (user_io_en !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(16'(user_io_en), 16'h0001);
      chk(16'(exp_q.size()), 16'h0000);
   endtask
   task restart(input int lo, input logic prog, input logic pre);
      @(posedge clk);
      config_reset_n <= 1'b0;
      store_programmed <= prog;
      ram_preload_en <= pre;
      cyc(lo);
      config_reset_n <= 1'b1;
      cyc(4);
   endtask
   task ext_rd(input logic [15:0] a, input logic sec, input logic [7:0] e);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         security_set <= sec;
         ext_rd_en <= 1'b1;
         ext_rd_addr <= a;
         @(posedge clk);
         ext_rd_en <= 1'b0;
         #1 if (k == 1) chk(16'(ext_rd_data), 16'(e));
      end
   endtask
   task host_byte(input logic [7:0] b);
      #1.3;
      for (int i = 7; i >= 0; i--) begin
         per_sdi_i = b[i];
         #3 spi_sck_i = 1'b1;
         #3 spi_sck_i = 1'b0;
      end
   endtask
   // Random stalls on the stream; the 4-byte flash load never fills the FIFO, so the flash clock pauses only the one cycle each byte spends in the hold register.
   always @(posedge clk) begin
      cfg_ready <= !rand_en || ($urandom % 3 != 0);
   end
   always @(posedge clk) begin
      if (!rst && cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
         if (exp_q.size() == 0) chk(16'(cfg_data), 16'h0100);
         else chk(16'(cfg_data), 16'(exp_q.pop_front()));
      end
   end
   initial begin
      #100us;
      err_count++;
      final_report();
   end
   initial begin
      void'($urandom(46241));
      {clk, spi_sck_i, per_sdi_i, security_set, ext_rd_en, prog_wr_en} = '0;
      {ram_we_i, rand_en, ram_re, host_en} = 4'hC;
      {rst, supplies_ok, config_reset_n, host_ss, store_programmed, ram_preload_en} = '1;
      {ext_rd_addr, prog_wr_addr, ram_array_q, prog_wr_data} = '0;
      cfg_ready = 1'b1;
      err_count = 0;
      tests_run = 0;
      push_exp(1'b0, LB + RB);
      cyc(8);
      rst <= 1'b0;
      cyc(8);
      // The select pin now falls, but the source was already chosen.
      host_en <= 1'b1;
      host_ss <= 1'b0;
      prog_wr_en <= 1'b1;
      cyc(1);
      prog_wr_en <= 1'b0;
      #1 chk(16'(ram_we_o), 16'h0000);
      wait_user();
      host_en <= 1'b0;
      #1 chk(16'(ram_we_o), 16'h0001);
      repeat (3) begin
         v = 16'($urandom);
         @(posedge clk);
         ram_re <= 1'b1;
         ram_array_q <= v;
         @(posedge clk);
         ram_re <= 1'b0;
         #1 chk(ram_rd_data, v);
      end
      ext_rd(16'h0005, 1'b0, 8'h39);
      ext_rd(16'h0005, 1'b1, 8'h00);
      @(posedge clk);
      security_set <= 1'b0;
      prog_wr_en <= 1'b1;
      prog_wr_addr <= 16'h0012;
      prog_wr_data <= 8'h77;
      @(posedge clk);
      prog_wr_en <= 1'b0;
      #1 chk({7'h00, store_wr_en, store_wr_data}, 16'h0177);
      restart(20, 1'b1, 1'b0);
      cyc(12);
      #1 chk(16'(user_io_en), 16'h0001);
      push_exp(1'b1, LB);
      restart(70, 1'b0, 1'b0);
      wait_user();
      @(posedge clk);
      rand_en <= 1'b0;
      host_en <= 1'b1;
      host_ss <= 1'b0;
      restart(70, 1'b1, 1'b1);
      cyc(12);
      repeat (LB + RB) begin
         v = 16'($urandom);
         exp_q.push_back(v[7:0]);
         host_byte(v[7:0]);
      end
      cyc(4);
      host_ss <= 1'b1;
      wait_user();
      host_en <= 1'b0;
      push_exp(1'b0, LB);
      ram_preload_en <= 1'b0;
      supplies_ok <= 1'b0;
      cyc(6);
      #1 chk(16'(user_io_en), 16'h0000);
      @(posedge clk);
      supplies_ok <= 1'b1;
      wait_user();
      final_report();
   end
endmodule
